// ### pcs_done_peer.sv
`timescale 1ns/10ps
// ***********************************************************
// other device sharing the wired completion pin
// ***********************************************************
module pcs_done_peer (
   input wire logic done_o_i, // device drive value
   input wire logic done_oe_i, // device output enable
   input wire logic hold_low_i, // peer pulls the pin low
   output logic pin_o // resolved pin level
);
   // a released pin floats to the pull-up; any low driver wins the wire
   assign pin_o = (done_oe_i ? done_o_i : 1'b1) & ~hold_low_i;
endmodule

// ### pcs_event_flag.sv
`timescale 1ns/10ps
// ***********************************************************
// sticky startup event flag, fired in its programmed phase
// ***********************************************************
module pcs_event_flag #(
   parameter logic INIT = 1'b0
) (
   input wire logic clock_i, // configuration clock
   input wire logic rst_n_i, // async reset, active low
   input wire logic clear_i, // back to INIT, new sequence
   input wire logic running_i, // sequencer is stepping
   input wire logic [2:0] phase_i, // current phase
   input wire logic [2:0] target_i, // programmed phase
   output logic flag_o // event state
);

   logic fire;

   assign fire = running_i && (phase_i == target_i);

   // fire wins over clear so an event is never lost
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flag_o <= INIT;
      end else if (fire) begin
         flag_o <= ~INIT;
      end else if (clear_i) begin
         flag_o <= INIT;
      end
   end

endmodule

// ### pcs_pkg.sv
package pcs_pkg;

   // ***********************************************************
   // bus and register map
   // ***********************************************************
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 32;
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_PHASE = 4'h4;
   localparam logic [3:0] OFS_STATUS = 4'h8;

   // ctrl register fields
   localparam int unsigned CTRL_START_BIT = 0;
   localparam int unsigned CTRL_DRIVE_BIT = 1;
   localparam int unsigned CTRL_LOCK_WAIT_BIT = 2;
   localparam int unsigned CTRL_MATCH_WAIT_BIT = 3;

   // phase register fields, three bits each
   localparam int unsigned PH_DONE_LSB = 0;
   localparam int unsigned PH_GTS_LSB = 4;
   localparam int unsigned PH_GWE_LSB = 8;
   localparam int unsigned PH_LOCK_LSB = 12;
   localparam int unsigned PH_MATCH_LSB = 16;

   // status register fields
   localparam int unsigned ST_PHASE_LSB = 0;
   localparam int unsigned ST_RUNNING_BIT = 3;
   localparam int unsigned ST_RELEASE_BIT = 4;
   localparam int unsigned ST_PIN_BIT = 5;
   localparam int unsigned ST_GWE_BIT = 6;
   localparam int unsigned ST_GTS_BIT = 7;
   localparam int unsigned ST_EOS_BIT = 8;
   localparam int unsigned ST_MATCH_BIT = 9;
   localparam int unsigned ST_LOCK_BIT = 10;
   localparam int unsigned ST_ORDER_BIT = 11;

   // ***********************************************************
   // phases and reset values
   // ***********************************************************
   localparam logic [2:0] PHASE_FIRST = 3'h0;
   localparam logic [2:0] PHASE_MIN_EVT = 3'h1;
   localparam logic [2:0] PHASE_MAX_EVT = 3'h6;
   localparam logic [2:0] PHASE_LAST = 3'h7;
   localparam logic [2:0] RST_DONE_PH = 3'h4;
   localparam logic [2:0] RST_GTS_PH = 3'h5;
   localparam logic [2:0] RST_GWE_PH = 3'h6;
   localparam logic [2:0] RST_LOCK_PH = 3'h1;
   localparam logic [2:0] RST_MATCH_PH = 3'h1;
   localparam logic RST_DRIVE = 1'b0;
   localparam logic RST_LOCK_WAIT = 1'b0;
   localparam logic RST_MATCH_WAIT = 1'b0;

   typedef enum logic [1:0] {
      PCS_IDLE = 2'h0,
      PCS_RUN = 2'h1,
      PCS_FINISH = 2'h3
   } pcs_state_t;

endpackage

// ### pcs_startup.sv
// The address map and the Avalon-MM slave port were decided locally.
`timescale 1ns/10ps
// Functional notes
// - startup begins only on start command with configuration frames loaded
// - sequencer walks eight phases, zero through seven
// - optional hold in a chosen phase 1-6 until all clock managers lock
// - optional hold in a chosen phase 1-6 until all impedance controllers match
// - phases of write enable, tristate, pin release and waits are programmable
// - end of startup always asserted in phase seven
// - defaults: release pin 4, tristate off 5, write enable 6, end 7
// - after releasing the completion pin, no advance until pin reads high
// - completion pin is open drain by default, release means high-impedance
// - an option turns on an active driver for the completion pin
// - internal release status is kept, may differ from pin level
// - write enable low keeps all synchronous elements frozen
// - tristate asserted disables all user io drivers
// - end of startup is readable in the status register
// - matched status true only when every impedance controller matched
// - waits should come before pin release, tristate removal and write enable
module pcs_startup #(
   parameter int unsigned NUM_CLK_MGR = 1,
   parameter int unsigned NUM_IMP_CTL = 1
) (
   input wire logic clock_i, // configuration clock, 250 MHz
   input wire logic rst_n_i, // async reset, active low
   input wire logic [pcs_pkg::ADDR_W-1:0] avs_address_i, // byte address
   input wire logic avs_read_i, // read request
   input wire logic avs_write_i, // write request
   input wire logic [pcs_pkg::DATA_W-1:0] avs_writedata_i, // write data
   input wire logic [3:0] avs_byteenable_i, // write byte lanes
   output logic [pcs_pkg::DATA_W-1:0] avs_readdata_o, // read data
   output logic avs_waitrequest_o, // high until answer
   input wire logic frames_loaded_i, // configuration frames loaded
   input wire logic [NUM_CLK_MGR-1:0] clock_manager_lock_i, // per-manager lock
   input wire logic [NUM_IMP_CTL-1:0] impedance_controller_match_i, // per-ctl match
   input wire logic done_i, // sensed completion pin level
   output logic done_o, // completion pin drive value
   output logic done_oe_o, // completion pin output enable
   output logic global_write_enable_o, // high lets user state change
   output logic global_io_tristate_o, // high disables user io
   output logic end_of_startup_o // startup complete
);

   // ***********************************************************
   // register bus slave
   // ***********************************************************
   logic wait_r;
   logic [pcs_pkg::DATA_W-1:0] rdata_r;
   logic req;
   logic acc;
   logic wr_acc;
   logic [pcs_pkg::DATA_W-1:0] status_word;
   logic [pcs_pkg::DATA_W-1:0] ctrl_word;
   logic [pcs_pkg::DATA_W-1:0] phase_word;
   logic [pcs_pkg::DATA_W-1:0] rd_mux;
   logic [pcs_pkg::DATA_W-1:0] wr_merged;

   assign req = avs_read_i || avs_write_i;
   // the access completes in the cycle in which waitrequest is low
   assign acc = req && !wait_r;
   assign wr_acc = acc && avs_write_i;

   function automatic logic [pcs_pkg::DATA_W-1:0] be_merge(
      input logic [pcs_pkg::DATA_W-1:0] old_v,
      input logic [pcs_pkg::DATA_W-1:0] new_v,
      input logic [3:0] be
   );
      logic [pcs_pkg::DATA_W-1:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // phase fields outside 1..6 are pulled into range, 0 and 7 are fixed
   function automatic logic [2:0] clamp_phase(input logic [2:0] p);
      logic [2:0] res;
      res = p;
      if (p < pcs_pkg::PHASE_MIN_EVT) begin
         res = pcs_pkg::PHASE_MIN_EVT;
      end else if (p > pcs_pkg::PHASE_MAX_EVT) begin
         res = pcs_pkg::PHASE_MAX_EVT;
      end
      return res;
   endfunction

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wait_r <= 1'b1;
      end else begin
         wait_r <= !(req && wait_r);
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_r <= '0;
      end else if (avs_read_i && wait_r) begin
         rdata_r <= rd_mux;
      end
   end

   assign avs_waitrequest_o = wait_r;
   assign avs_readdata_o = rdata_r;

   // ***********************************************************
   // configuration registers
   // ***********************************************************
   logic drive_r;
   logic lock_wait_r;
   logic match_wait_r;
   logic [2:0] done_ph_r;
   logic [2:0] gts_ph_r;
   logic [2:0] gwe_ph_r;
   logic [2:0] lock_ph_r;
   logic [2:0] match_ph_r;
   logic start_cmd;
   logic running;

   assign ctrl_word = {28'h0, match_wait_r, lock_wait_r, drive_r, 1'b0};
   assign phase_word = {13'h0, match_ph_r, 1'b0, lock_ph_r, 1'b0, gwe_ph_r,
                        1'b0, gts_ph_r, 1'b0, done_ph_r};

   always_comb begin
      wr_merged = '0;
      if (avs_address_i == pcs_pkg::OFS_CTRL) begin
         wr_merged = be_merge(ctrl_word, avs_writedata_i, avs_byteenable_i);
      end else if (avs_address_i == pcs_pkg::OFS_PHASE) begin
         wr_merged = be_merge(phase_word, avs_writedata_i, avs_byteenable_i);
      end
   end

   assign start_cmd = wr_acc && (avs_address_i == pcs_pkg::OFS_CTRL) &&
                      wr_merged[pcs_pkg::CTRL_START_BIT];

   // options are frozen while the sequencer runs so a phase never moves under it
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         drive_r <= pcs_pkg::RST_DRIVE;
         lock_wait_r <= pcs_pkg::RST_LOCK_WAIT;
         match_wait_r <= pcs_pkg::RST_MATCH_WAIT;
      end else if (wr_acc && (avs_address_i == pcs_pkg::OFS_CTRL) && !running) begin
         drive_r <= wr_merged[pcs_pkg::CTRL_DRIVE_BIT];
         lock_wait_r <= wr_merged[pcs_pkg::CTRL_LOCK_WAIT_BIT];
         match_wait_r <= wr_merged[pcs_pkg::CTRL_MATCH_WAIT_BIT];
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         done_ph_r <= pcs_pkg::RST_DONE_PH;
         gts_ph_r <= pcs_pkg::RST_GTS_PH;
         gwe_ph_r <= pcs_pkg::RST_GWE_PH;
         lock_ph_r <= pcs_pkg::RST_LOCK_PH;
         match_ph_r <= pcs_pkg::RST_MATCH_PH;
      end else if (wr_acc && (avs_address_i == pcs_pkg::OFS_PHASE) && !running) begin
         done_ph_r <= clamp_phase(wr_merged[pcs_pkg::PH_DONE_LSB +: 3]);
         gts_ph_r <= clamp_phase(wr_merged[pcs_pkg::PH_GTS_LSB +: 3]);
         gwe_ph_r <= clamp_phase(wr_merged[pcs_pkg::PH_GWE_LSB +: 3]);
         lock_ph_r <= clamp_phase(wr_merged[pcs_pkg::PH_LOCK_LSB +: 3]);
         match_ph_r <= clamp_phase(wr_merged[pcs_pkg::PH_MATCH_LSB +: 3]);
      end
   end

   // ***********************************************************
   // lock and match status
   // ***********************************************************
   logic all_locked;
   logic impedance_matched;
   logic clock_managers_locked;
   logic order_warn;

   assign all_locked = &clock_manager_lock_i;
   assign impedance_matched = &impedance_controller_match_i;
   // lock only shows the real managers when the wait is in use
   assign clock_managers_locked = lock_wait_r ? all_locked : 1'b1;

   // flags a wait placed at or after a visible event; user io could run unlocked
   always_comb begin
      order_warn = 1'b0;
      if (lock_wait_r && ((lock_ph_r >= done_ph_r) || (lock_ph_r >= gts_ph_r) ||
                          (lock_ph_r >= gwe_ph_r))) begin
         order_warn = 1'b1;
      end
      if (match_wait_r && ((match_ph_r >= done_ph_r) || (match_ph_r >= gts_ph_r) ||
                           (match_ph_r >= gwe_ph_r))) begin
         order_warn = 1'b1;
      end
   end

   // ***********************************************************
   // phase sequencer
   // ***********************************************************
   pcs_pkg::pcs_state_t state_r;
   logic [2:0] phase_r;
   logic hold_lock;
   logic hold_match;
   logic hold_done;
   logic release_done;
   logic eos_r;

   assign running = (state_r == pcs_pkg::PCS_RUN);
   assign hold_lock = lock_wait_r && (phase_r == lock_ph_r) && !all_locked;
   assign hold_match = match_wait_r && (phase_r == match_ph_r) && !impedance_matched;
   // other devices holding the pin low stall this phase too
   assign hold_done = (phase_r == done_ph_r) && !(release_done && done_i);

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= pcs_pkg::PCS_IDLE;
      end else begin
         unique case (state_r)
            pcs_pkg::PCS_IDLE: begin
               if (start_cmd && frames_loaded_i) begin
                  state_r <= pcs_pkg::PCS_RUN;
               end
            end
            pcs_pkg::PCS_RUN: begin
               if (phase_r == pcs_pkg::PHASE_LAST) begin
                  state_r <= pcs_pkg::PCS_FINISH;
               end
            end
            pcs_pkg::PCS_FINISH: begin
               state_r <= pcs_pkg::PCS_FINISH;
            end
            default: begin
               state_r <= pcs_pkg::PCS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase_r <= pcs_pkg::PHASE_FIRST;
      end else if (running && (phase_r != pcs_pkg::PHASE_LAST) &&
                   !hold_lock && !hold_match && !hold_done) begin
         phase_r <= phase_r + 3'h1;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         eos_r <= 1'b0;
      end else if (running && (phase_r == pcs_pkg::PHASE_LAST)) begin
         eos_r <= 1'b1;
      end
   end

   assign end_of_startup_o = eos_r;

   // ***********************************************************
   // startup events
   // ***********************************************************
   pcs_event_flag #(
      .INIT(1'b0)
   ) u_release (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .clear_i(start_cmd),
      .running_i(running),
      .phase_i(phase_r),
      .target_i(done_ph_r),
      .flag_o(release_done)
   );

   pcs_event_flag #(
      .INIT(1'b1)
   ) u_tristate (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .clear_i(start_cmd),
      .running_i(running),
      .phase_i(phase_r),
      .target_i(gts_ph_r),
      .flag_o(global_io_tristate_o)
   );

   pcs_event_flag #(
      .INIT(1'b0)
   ) u_write_enable (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .clear_i(start_cmd),
      .running_i(running),
      .phase_i(phase_r),
      .target_i(gwe_ph_r),
      .flag_o(global_write_enable_o)
   );

   // ***********************************************************
   // completion pin
   // ***********************************************************
   logic done_oe_r;
   logic done_out_r;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         done_oe_r <= 1'b1;
         done_out_r <= 1'b0;
      end else if (drive_r) begin
         done_oe_r <= 1'b1;
         done_out_r <= release_done;
      end else begin
         done_oe_r <= !release_done;
         done_out_r <= 1'b0;
      end
   end

   assign done_o = done_out_r;
   assign done_oe_o = done_oe_r;

   // ***********************************************************
   // status word
   // ***********************************************************
   always_comb begin
      status_word = '0;
      status_word[pcs_pkg::ST_PHASE_LSB +: 3] = phase_r;
      status_word[pcs_pkg::ST_RUNNING_BIT] = running;
      status_word[pcs_pkg::ST_RELEASE_BIT] = release_done;
      status_word[pcs_pkg::ST_PIN_BIT] = done_i;
      status_word[pcs_pkg::ST_GWE_BIT] = global_write_enable_o;
      status_word[pcs_pkg::ST_GTS_BIT] = global_io_tristate_o;
      status_word[pcs_pkg::ST_EOS_BIT] = eos_r;
      status_word[pcs_pkg::ST_MATCH_BIT] = impedance_matched;
      status_word[pcs_pkg::ST_LOCK_BIT] = clock_managers_locked;
      status_word[pcs_pkg::ST_ORDER_BIT] = order_warn;
   end

   // unmapped offsets answer with zero
   always_comb begin
      rd_mux = '0;
      if (avs_address_i == pcs_pkg::OFS_CTRL) begin
         rd_mux = ctrl_word;
      end else if (avs_address_i == pcs_pkg::OFS_PHASE) begin
         rd_mux = phase_word;
      end else if (avs_address_i == pcs_pkg::OFS_STATUS) begin
         rd_mux = status_word;
      end
   end

   // ***********************************************************
   // checks
   // ***********************************************************
   a_start_needs_frames: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      $rose(running) |-> $past(frames_loaded_i) && $past(start_cmd))
      else $error("sequencer started without loaded frames and command");

   a_one_phase_step: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      running |=> (phase_r == $past(phase_r)) || (phase_r == $past(phase_r) + 3'h1))
      else $error("phase moved by more than one step");

   a_lock_wait_hold: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      (running && lock_wait_r && phase_r == lock_ph_r && !all_locked) |=> $stable(phase_r))
      else $error("phase advanced before clock managers locked");

   a_match_wait_hold: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      (running && match_wait_r && phase_r == match_ph_r && !impedance_matched)
      |=> $stable(phase_r))
      else $error("phase advanced before impedance match");

   a_pin_high_hold: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      (running && phase_r == done_ph_r && !done_i) |=> $stable(phase_r))
      else $error("phase advanced while completion pin low");

   a_eos_last_phase: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      $rose(end_of_startup_o) |-> $past(phase_r) == pcs_pkg::PHASE_LAST
      ##1 end_of_startup_o [*3])
      else $error("end of startup outside last phase");

   a_gwe_in_phase: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      $rose(global_write_enable_o) |-> $past(phase_r) == $past(gwe_ph_r))
      else $error("write enable asserted in wrong phase");

   a_gts_in_phase: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      $fell(global_io_tristate_o) |-> $past(phase_r) == $past(gts_ph_r))
      else $error("tristate removed in wrong phase");

   a_open_drain_pin: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      (!drive_r && $stable(drive_r) && $stable(release_done))
      |-> !done_o && (done_oe_o == !release_done))
      else $error("open drain pin driven high or not released");

   a_active_pin: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      (drive_r && $stable(drive_r) && $stable(release_done))
      |-> done_oe_o && (done_o == release_done))
      else $error("active pin driver wrong");

   a_lock_status: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      !lock_wait_r |-> status_word[pcs_pkg::ST_LOCK_BIT])
      else $error("lock status low without lock wait");

endmodule

// ### tb.sv
`timescale 1ns/10ps
module tb;
   // ***********************************************************
   // signals and instances
   // ***********************************************************
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] addr = 4'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic wait_req;
   logic frames = 1'b0;
   logic lock = 1'b0;
   logic match = 1'b0;
   logic hold = 1'b0;
   logic pin;
   logic done_drv;
   logic done_oe;
   logic global_write_enable;
   logic global_io_tristate;
   logic end_of_startup;
   logic [31:0] rv;
   int n_fail = 0;
   int total_checks = 0;
   int cyc = 0;
   int tg;
   int tw;
   int te;

   always #2 clk = ~clk;

   pcs_startup i_pcs_startup (
      .clock_i(clk), .rst_n_i(rst_n), .avs_address_i(addr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
      .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req), .frames_loaded_i(frames),
      .clock_manager_lock_i(lock), .impedance_controller_match_i(match), .done_i(pin),
      .done_o(done_drv), .done_oe_o(done_oe), .global_write_enable_o(global_write_enable),
      .global_io_tristate_o(global_io_tristate), .end_of_startup_o(end_of_startup));

   pcs_done_peer i_pcs_done_peer (
      .done_o_i(done_drv), .done_oe_i(done_oe), .hold_low_i(hold), .pin_o(pin));

   // ***********************************************************
   // shared tasks
   // ***********************************************************
   task automatic end_sim;
      $display("checks %0d, failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // cut short a hung wait; the whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         end_sim();
      end
   end

   task automatic chk(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask

   // request held until waitrequest is sampled low
   task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wr <= we;
      rd <= ~we;
      wdata <= d;
      do @(posedge clk); while (wait_req !== 1'b0);
      rv = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
                         input string msg);
      bus(1'b0, a, 32'h0);
      chk((rv & m) === e, msg);
   endtask

   task automatic do_reset;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
   endtask

   // cycle index at which tristate falls, write enable rises, end rises
   task automatic watch;
      tg = -1;
      tw = -1;
      te = -1;
      for (int i = 0; i < 60; i++) begin
         @(posedge clk);
         #1;
         if (tg < 0 && global_io_tristate === 1'b0) tg = i;
         if (tw < 0 && global_write_enable === 1'b1) tw = i;
         if (te < 0 && end_of_startup === 1'b1) te = i;
      end
   endtask

   // ***********************************************************
   // scenarios
   // ***********************************************************
   task automatic reset_values;
      chk(done_oe === 1'b1 && done_drv === 1'b0, "pin not driven low");
      chk(global_write_enable === 1'b0 && global_io_tristate === 1'b1 && end_of_startup === 1'b0, "event outputs");
      rd_chk(pcs_pkg::OFS_CTRL, 32'hFFFFFFFF, 32'h00000000, "ctrl reset");
      rd_chk(pcs_pkg::OFS_PHASE, 32'hFFFFFFFF, 32'h00011654, "phase reset");
      rd_chk(4'hC, 32'hFFFFFFFF, 32'h00000000, "unmapped read");
      rd_chk(pcs_pkg::OFS_STATUS, 32'h00000FFF, 32'h00000480, "status reset");
      @(posedge clk);
      match <= 1'b1;
      rd_chk(pcs_pkg::OFS_STATUS, 32'h00000200, 32'h00000200, "match status");
      bus(1'b1, pcs_pkg::OFS_CTRL, 32'h00000001);
      rd_chk(pcs_pkg::OFS_STATUS, 32'h0000000F, 32'h00000000, "started early");
   endtask

   task automatic default_run;
      @(posedge clk);
      frames <= 1'b1;
      hold <= 1'b1;
      bus(1'b1, pcs_pkg::OFS_CTRL, 32'h00000001);
      for (int i = 0; i < 50 && done_oe !== 1'b0; i++) @(posedge clk);
      repeat (4) @(posedge clk);
      // peer still holds the pin low: release seen, sequence parked in 4
      rd_chk(pcs_pkg::OFS_STATUS, 32'h000001FF, 32'h0000009C, "held status");
      chk(global_io_tristate === 1'b1 && global_write_enable === 1'b0, "early events");
      @(posedge clk);
      hold <= 1'b0;
      watch();
      chk(tg === 1 && tw === 2 && te === 3, "default timing");
      rd_chk(pcs_pkg::OFS_STATUS, 32'h000001F8, 32'h00000170, "end status");
   endtask

   task automatic waits_and_drive;
      do_reset();
      @(posedge clk);
      lock <= 1'b0;
      match <= 1'b0;
      bus(1'b1, pcs_pkg::OFS_CTRL, 32'h0000000E);
      bus(1'b1, pcs_pkg::OFS_PHASE, 32'h00021763);
      rd_chk(pcs_pkg::OFS_PHASE, 32'hFFFFFFFF, 32'h00021663, "phase clamp");
      // lock wait in phase 4, after the pin release in phase 3
      bus(1'b1, pcs_pkg::OFS_PHASE, 32'h00024563);
      rd_chk(pcs_pkg::OFS_STATUS, 32'h00000800, 32'h00000800, "order warning");
      bus(1'b1, pcs_pkg::OFS_PHASE, 32'h00021563);
      rd_chk(pcs_pkg::OFS_CTRL, 32'hFFFFFFFF, 32'h0000000E, "ctrl options");
      bus(1'b1, pcs_pkg::OFS_CTRL, 32'h0000000F);
      rd_chk(pcs_pkg::OFS_STATUS, 32'h00000C0F, 32'h00000009, "lock hold");
      @(posedge clk);
      lock <= 1'b1;
      rd_chk(pcs_pkg::OFS_STATUS, 32'h0000000F, 32'h0000000A, "match hold");
      @(posedge clk);
      match <= 1'b1;
      watch();
      chk(tw > 0 && tg === tw + 1 && te === tg + 1, "moved events");
      chk(done_oe === 1'b1 && done_drv === 1'b1, "active driver");
   endtask

   initial begin
      do_reset();
      reset_values();
      default_run();
      waits_and_drive();
      end_sim();
   end
endmodule
